/* rtl/chgi_target.sv */
// How it works
// - Target only, answers bus address 0x6A.
// - Reads above register 0x0C return 0xFF.
// - Works at 100 and 400 kbit/s.
// - Open-drain lines; idle when both high.
// - Data changes only while clock low.
// - Master makes start/stop; busy between them.
// - Eight bits, MSB first, each byte acked.
// - Receiver pulls data low on ninth clock.
// - After not-acknowledge master stops or restarts.
// - Master waits while clock held low.
// - First byte: address plus direction bit.
// - Undefined register address: nack, go idle.
// - Multi-byte reads and writes over 0x00-0x0C.
// - Fault/status bits latched until read once.
// - One interrupt until latched bits cleared.
// - Overcurrent latches FET off into ship mode.
// - Reset into default mode; flag shows mode.
// - Default mode charges under ten-hour timer.
// - Any register write enters host mode.
// - Host kicks watchdog or disables it.
//
// Our own choice: the plain strobed port.
`timescale 1ns/1ns
`include "chgi_regs.svh"
`default_nettype none

module chgi_target #(
  parameter int unsigned     INT_CYCLES      =
    `CHGI_INT_PULSE_US * `CHGI_CLK_MHZ,
  parameter longint unsigned SAFETY_CYCLES   =
    64'(`CHGI_SAFETY_HOURS) * 64'(`CHGI_SEC_PER_HOUR) *
    64'(`CHGI_US_PER_SEC) * 64'(`CHGI_CLK_MHZ),
  parameter int unsigned     WDT_STEP_CYCLES = 32'h05f5_e100,
  // Arbitrary value, no meaning beyond a recognisable pattern
  parameter logic [7:0]      PART_INFO       = 8'h5a
) (
  // Clock and reset
  input  wire logic       core_clk_i,
  input  wire logic       rst_b_i,
  // Two-wire link
  chgi_link_if.target     link,
  // Live charger status, same clock domain
  input  wire logic [7:0] stat0_i,
  input  wire logic [7:0] fault_i,
  input  wire logic [7:0] stat2_i,
  // Protection events
  input  wire logic       discharge_current_limit_hit_i,
  input  wire logic       ship_exit_i,
  // Charger control and notification
  output logic            battery_fet_on_o,
  output logic            ship_mode_o,
  output logic            host_mode_o,
  output logic            charge_en_o,
  output logic            int_b_o
);
  chgi_pkg::chgi_tgt_t s;
  chgi_pkg::chgi_tgt_t next_s;
  logic [1:0]  lines;
  logic        scl_s;
  logic        sda_s;
  logic        scl_rise;
  logic        scl_fall;
  logic        start_c;
  logic        stop_c;
  logic        clr_fault;
  logic        clr_stat2;
  logic        wr_any;
  logic        kick;
  logic        ev;
  logic [7:0]  rd_byte;
  logic [31:0] wdt_lim;

  chgi_sync u_sync (
    .core_clk_i (core_clk_i),
    .rst_b_i    (rst_b_i),
    .line_i     ({link.scl, link.sda}),
    .line_o     (lines)
  );

  assign scl_s = lines[1];
  assign sda_s = lines[0];
  assign scl_rise = scl_s && !s.scl_q;
  assign scl_fall = !scl_s && s.scl_q;
  assign start_c = scl_s && s.scl_q && s.sda_q && !sda_s;
  assign stop_c  = scl_s && s.scl_q && !s.sda_q && sda_s;

  function automatic logic [7:0] read_reg(input logic [7:0] a);
    logic [7:0] v;
    v = `CHGI_UNMAPPED;
    if (a == `CHGI_REG_FAULT) begin
      v = s.lat09;
      v[`CHGI_WDOG_FLAG] = s.lat09[`CHGI_WDOG_FLAG] | s.dflt;
    end else if (a == `CHGI_REG_STAT2) begin
      v = stat2_i;
      v[`CHGI_LAT_HI:`CHGI_LAT_LO] = s.lat0a;
    end else if (a == `CHGI_REG_STAT0) begin
      v = stat0_i;
    end else if (a == `CHGI_REG_PART) begin
      v = PART_INFO;
    end else if (a <= `CHGI_LAST_REG) begin
      v = s.regs[a[3:0]];
    end
    return v;
  endfunction

  always_comb begin
    next_s = s;
    next_s.scl_q = scl_s;
    next_s.sda_q = sda_s;
    clr_fault = 1'b0;
    clr_stat2 = 1'b0;
    wr_any = 1'b0;
    kick = 1'b0;
    rd_byte = read_reg(s.ptr);
    if (start_c) begin
      // A repeated start also lands here
      next_s.st = chgi_pkg::CHGI_T_ADDR;
      next_s.bitn = 4'h0;
      next_s.ack_ph = 1'b0;
      next_s.sda_oe = 1'b0;
    end else if (stop_c) begin
      next_s.st = chgi_pkg::CHGI_T_IDLE;
      next_s.sda_oe = 1'b0;
    end else if (s.st != chgi_pkg::CHGI_T_IDLE) begin
      if (scl_rise) begin
        if (s.bitn < `CHGI_BYTE_BITS) begin
          next_s.sh = {s.sh[6:0], sda_s};
          next_s.bitn = s.bitn + 4'h1;
        end else if (s.st == chgi_pkg::CHGI_T_RD) begin
          next_s.nack_rx = sda_s;
        end
      end else if (scl_fall) begin
        if (s.bitn == `CHGI_BYTE_BITS && !s.ack_ph) begin
          next_s.ack_ph = 1'b1;
          next_s.sda_oe = 1'b0;
          case (s.st)
            chgi_pkg::CHGI_T_ADDR: begin
              if (s.sh[7:1] == `CHGI_TGT_ADDR) begin
                next_s.sda_oe = 1'b1;
                next_s.nack_rx = 1'b0;
                next_s.st = s.sh[0] ? chgi_pkg::CHGI_T_RD
                                    : chgi_pkg::CHGI_T_REG;
              end else begin
                next_s.st = chgi_pkg::CHGI_T_IDLE;
              end
            end
            chgi_pkg::CHGI_T_REG: begin
              if (s.sh <= `CHGI_LAST_REG) begin
                next_s.ptr = s.sh;
                next_s.sda_oe = 1'b1;
                next_s.st = chgi_pkg::CHGI_T_WR;
              end else begin
                next_s.st = chgi_pkg::CHGI_T_IDLE;
              end
            end
            chgi_pkg::CHGI_T_WR: begin
              next_s.sda_oe = 1'b1;
              next_s.ptr = s.ptr + 8'h01;
              wr_any = 1'b1;
              // Status slots are read-only; the write is acked and dropped
              if (s.ptr < `CHGI_REG_STAT0 || s.ptr == `CHGI_LAST_REG) begin
                next_s.regs[s.ptr[3:0]] = s.sh;
              end
              if (s.ptr == `CHGI_REG_CTRL0) begin
                // The kick bit clears itself and always reads 0
                next_s.regs[s.ptr[3:0]][`CHGI_KICK_BIT] = 1'b0;
                kick = s.sh[`CHGI_KICK_BIT];
              end
            end
            chgi_pkg::CHGI_T_RD: begin
              next_s.sda_oe = 1'b0;
            end
            default: begin
              next_s.st = chgi_pkg::CHGI_T_IDLE;
            end
          endcase
        end else if (s.ack_ph) begin
          next_s.ack_ph = 1'b0;
          next_s.bitn = 4'h0;
          next_s.sda_oe = 1'b0;
          if (s.st == chgi_pkg::CHGI_T_RD) begin
            if (s.nack_rx) begin
              next_s.st = chgi_pkg::CHGI_T_IDLE;
            end else begin
              next_s.sh = rd_byte;
              next_s.sda_oe = !rd_byte[7];
              next_s.ptr = s.ptr + 8'h01;
              clr_fault = (s.ptr == `CHGI_REG_FAULT);
              clr_stat2 = (s.ptr == `CHGI_REG_STAT2);
            end
          end
        end else if (s.st == chgi_pkg::CHGI_T_RD) begin
          next_s.sda_oe = !s.sh[7];
        end
      end
    end

    // A change arriving with the read still latches: set wins
    ev = |(fault_i & ~s.lat09) ||
         |(stat2_i[`CHGI_LAT_HI:`CHGI_LAT_LO] & ~s.lat0a);
    next_s.lat09 = fault_i | (clr_fault ? 8'h00 : s.lat09);
    next_s.lat0a = stat2_i[`CHGI_LAT_HI:`CHGI_LAT_LO] |
                   (clr_stat2 ? 3'h0 : s.lat0a);
    if (s.int_cnt != 32'h0000_0000) begin
      next_s.int_cnt = s.int_cnt - 32'h0000_0001;
    end
    // A change landing just as the latches empty must still notify
    if (ev && (!s.int_pend || (s.lat09 == 8'h00 && s.lat0a == 3'h0))) begin
      next_s.int_pend = 1'b1;
      next_s.int_cnt = INT_CYCLES;
    end else if (s.lat09 == 8'h00 && s.lat0a == 3'h0) begin
      next_s.int_pend = 1'b0;
    end
    next_s.int_b = (next_s.int_cnt == 32'h0000_0000);

    wdt_lim = WDT_STEP_CYCLES *
      32'(s.regs[`CHGI_REG_CTRL1][`CHGI_WDT_HI:`CHGI_WDT_LO]);
    if (wr_any && s.dflt) begin
      next_s.dflt = 1'b0;
      next_s.wdt_cnt = 32'h0000_0000;
    end else if (kick) begin
      next_s.wdt_cnt = 32'h0000_0000;
    end else if (!s.dflt && wdt_lim != 32'h0000_0000) begin
      if (s.wdt_cnt >= wdt_lim - 32'h0000_0001) begin
        next_s.dflt = 1'b1;
        next_s.regs = `CHGI_REG_DEFAULTS;
        next_s.wdt_cnt = 32'h0000_0000;
      end else begin
        next_s.wdt_cnt = s.wdt_cnt + 32'h0000_0001;
      end
    end

    // Only charging stops at expiry; the system supply is untouched
    if (!s.dflt) begin
      next_s.saf_cnt = 48'h0000_0000_0000;
    end else if (s.saf_cnt < 48'(SAFETY_CYCLES)) begin
      next_s.saf_cnt = s.saf_cnt + 48'h0000_0000_0001;
    end
    next_s.chg_en = !next_s.dflt ||
                    (next_s.saf_cnt < 48'(SAFETY_CYCLES));

    if (discharge_current_limit_hit_i) begin
      next_s.ship = 1'b1;
    end else if (ship_exit_i) begin
      next_s.ship = 1'b0;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      s <= '0;
      s.regs <= `CHGI_REG_DEFAULTS;
      s.scl_q <= 1'b1;
      s.sda_q <= 1'b1;
      s.int_b <= 1'b1;
      s.dflt <= 1'b1;
      s.chg_en <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  // Pins only ever pull low; no clock stretching is needed here
  assign link.scl_tgt_o = 1'b0;
  assign link.scl_tgt_oe = 1'b0;
  assign link.sda_tgt_o = 1'b0;
  assign link.sda_tgt_oe = s.sda_oe;
  assign battery_fet_on_o = !s.ship;
  assign ship_mode_o = s.ship;
  assign host_mode_o = !s.dflt;
  assign charge_en_o = s.chg_en;
  assign int_b_o = s.int_b;
endmodule

`default_nettype wire

/* rtl/chgi_regs.svh */
`ifndef CHGI_REGS_SVH
`define CHGI_REGS_SVH

// Target address and register map
`define CHGI_TGT_ADDR     7'h6a
`define CHGI_LAST_REG     8'h0c
`define CHGI_UNMAPPED     8'hff
`define CHGI_REG_CTRL0    8'h01
`define CHGI_REG_CTRL1    8'h05
`define CHGI_REG_STAT0    8'h08
`define CHGI_REG_FAULT    8'h09
`define CHGI_REG_STAT2    8'h0a
`define CHGI_REG_PART     8'h0b
`define CHGI_KICK_BIT     6
`define CHGI_WDT_HI       5
`define CHGI_WDT_LO       4
`define CHGI_WDOG_FLAG    7
`define CHGI_LAT_HI       6
`define CHGI_LAT_LO       4
`define CHGI_REG_DEFAULTS {8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, \
  8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h1a, 8'h17}

// Link framing
`define CHGI_BYTE_BITS    4'h8

// Timing
`define CHGI_CLK_MHZ      100
`define CHGI_FAST_KHZ     400
`define CHGI_INT_PULSE_US 256
`define CHGI_SAFETY_HOURS 10
`define CHGI_SEC_PER_HOUR 3600
`define CHGI_US_PER_SEC   1000000

// Controller software port
`define CHGI_H_CTRL       4'h0
`define CHGI_H_PTR        4'h1
`define CHGI_H_WDATA      4'h2
`define CHGI_H_STATUS     4'h3
`define CHGI_H_RDATA      4'h4
`define CHGI_H_GO_WR      0
`define CHGI_H_GO_RD      1

// Controller sequence steps
`define CHGI_H_SEND_ADDR  3'h1
`define CHGI_H_SEND_PTR   3'h2
`define CHGI_H_SEND_DATA  3'h3
`define CHGI_H_RESTART    3'h3
`define CHGI_H_RX_STEP    3'h5
`define CHGI_H_STOP_WR    3'h4
`define CHGI_H_STOP_RD    3'h6

`endif

/* rtl/chgi_pkg.sv */
`include "chgi_regs.svh"

package chgi_pkg;

  typedef enum logic [2:0] {
    CHGI_T_IDLE, CHGI_T_ADDR, CHGI_T_REG, CHGI_T_WR, CHGI_T_RD
  } chgi_tst_t;

  typedef enum logic [1:0] {
    CHGI_OP_START, CHGI_OP_TX, CHGI_OP_RX, CHGI_OP_STOP
  } chgi_op_t;

  typedef struct packed {
    logic [1:0] meta;
    logic [1:0] safe;
  } chgi_sync_t;

  typedef struct packed {
    chgi_tst_t        st;
    logic [3:0]       bitn;
    logic             ack_ph;
    logic             nack_rx;
    logic [7:0]       sh;
    logic [7:0]       ptr;
    logic             scl_q;
    logic             sda_q;
    logic             sda_oe;
    logic [12:0][7:0] regs;
    logic [7:0]       lat09;
    logic [2:0]       lat0a;
    logic             int_pend;
    logic [31:0]      int_cnt;
    logic             int_b;
    logic             dflt;
    logic [31:0]      wdt_cnt;
    logic [47:0]      saf_cnt;
    logic             chg_en;
    logic             ship;
  } chgi_tgt_t;

  typedef struct packed {
    logic       busy;
    logic       rd_op;
    logic       nack;
    logic [2:0] step;
    logic [1:0] ph;
    logic [7:0] qcnt;
    logic [3:0] bitn;
    logic [7:0] sh;
    logic       scl_oe;
    logic       sda_oe;
    logic [7:0] ptr;
    logic [7:0] wdat;
    logic [7:0] rdat;
    logic [7:0] rdata;
  } chgi_host_t;

endpackage

/* rtl/chgi_link_if.sv */
`timescale 1ns/1ns
`default_nettype none

interface chgi_link_if;
  logic scl_tgt_o;
  logic scl_tgt_oe;
  logic sda_tgt_o;
  logic sda_tgt_oe;
  logic scl_ctl_o;
  logic scl_ctl_oe;
  logic sda_ctl_o;
  logic sda_ctl_oe;
  logic scl;
  logic sda;

  // Open-drain wires: pulled high unless someone drives a low
  assign scl = !((scl_tgt_oe && !scl_tgt_o) || (scl_ctl_oe && !scl_ctl_o));
  assign sda = !((sda_tgt_oe && !sda_tgt_o) || (sda_ctl_oe && !sda_ctl_o));

  modport target (
    input  scl, sda,
    output scl_tgt_o, scl_tgt_oe, sda_tgt_o, sda_tgt_oe
  );
  modport controller (
    input  scl, sda,
    output scl_ctl_o, scl_ctl_oe, sda_ctl_o, sda_ctl_oe
  );
endinterface

`default_nettype wire

/* rtl/chgi_sync.sv */
`timescale 1ns/1ns
`default_nettype none

module chgi_sync (
  // Clock and reset
  input  wire logic       core_clk_i,
  input  wire logic       rst_b_i,
  // Line levels from the wire and their settled copies
  input  wire logic [1:0] line_i,
  output logic      [1:0] line_o
);
  chgi_pkg::chgi_sync_t s;
  chgi_pkg::chgi_sync_t next_s;

  always_comb begin
    next_s.meta = line_i;
    next_s.safe = s.meta;
  end

  // Idle bus reads high, so reset to high avoids a false start
  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      s <= '1;
    end else begin
      s <= next_s;
    end
  end

  assign line_o = s.safe;
endmodule

`default_nettype wire

/* rtl/chgi_host.sv */
`timescale 1ns/1ns
`include "chgi_regs.svh"
`default_nettype none

module chgi_host (
  // Clock and reset
  input  wire logic       core_clk_i,
  input  wire logic       rst_b_i,
  // Two-wire link
  chgi_link_if.controller link,
  // Software port
  input  wire logic [3:0] addr_i,
  input  wire logic [7:0] wdata_i,
  input  wire logic       wr_i,
  input  wire logic       rd_i,
  output logic      [7:0] rdata_o,
  output logic            busy_o
);
  // Quarter bit, rounded up so the rate never exceeds fast mode
  localparam int unsigned QTR_CYC =
    (`CHGI_CLK_MHZ * 1000 + 4 * `CHGI_FAST_KHZ - 1) /
    (4 * `CHGI_FAST_KHZ);

  chgi_pkg::chgi_host_t s;
  chgi_pkg::chgi_host_t next_s;
  chgi_pkg::chgi_op_t   op;
  logic [1:0]           lines;
  logic                 scl_s;
  logic                 sda_s;
  logic                 tick;

  chgi_sync u_sync (
    .core_clk_i (core_clk_i),
    .rst_b_i    (rst_b_i),
    .line_i     ({link.scl, link.sda}),
    .line_o     (lines)
  );

  assign scl_s = lines[1];
  assign sda_s = lines[0];

  function automatic chgi_pkg::chgi_op_t step_op(input logic rd,
                                                 input logic [2:0] st);
    chgi_pkg::chgi_op_t o;
    o = chgi_pkg::CHGI_OP_TX;
    if (st == 3'h0 || (rd && st == `CHGI_H_RESTART)) begin
      o = chgi_pkg::CHGI_OP_START;
    end else if (st == (rd ? `CHGI_H_STOP_RD : `CHGI_H_STOP_WR)) begin
      o = chgi_pkg::CHGI_OP_STOP;
    end else if (rd && st == `CHGI_H_RX_STEP) begin
      o = chgi_pkg::CHGI_OP_RX;
    end
    return o;
  endfunction

  function automatic logic [7:0] tx_byte(input logic [2:0] st);
    logic [7:0] b;
    case (st)
      `CHGI_H_SEND_ADDR: b = {`CHGI_TGT_ADDR, 1'b0};
      `CHGI_H_SEND_PTR:  b = s.ptr;
      `CHGI_H_SEND_DATA: b = s.rd_op ? {`CHGI_TGT_ADDR, 1'b1} : s.wdat;
      default:           b = {`CHGI_TGT_ADDR, 1'b1};
    endcase
    return b;
  endfunction

  assign op = step_op(s.rd_op, s.step);
  assign tick = (s.qcnt == 8'(QTR_CYC - 1));

  always_comb begin
    next_s = s;
    next_s.rdata = 8'h00;
    if (rd_i) begin
      case (addr_i)
        `CHGI_H_PTR:    next_s.rdata = s.ptr;
        `CHGI_H_WDATA:  next_s.rdata = s.wdat;
        `CHGI_H_STATUS: next_s.rdata = {6'h00, s.nack, s.busy};
        `CHGI_H_RDATA:  next_s.rdata = s.rdat;
        default:        next_s.rdata = 8'h00;
      endcase
    end
    if (wr_i && !s.busy) begin
      // Software kicks the watchdog through these register writes
      if (addr_i == `CHGI_H_PTR) begin
        next_s.ptr = wdata_i;
      end else if (addr_i == `CHGI_H_WDATA) begin
        next_s.wdat = wdata_i;
      end else if (addr_i == `CHGI_H_CTRL &&
                   (wdata_i[`CHGI_H_GO_WR] || wdata_i[`CHGI_H_GO_RD])) begin
        next_s.busy = 1'b1;
        next_s.rd_op = wdata_i[`CHGI_H_GO_RD];
        next_s.nack = 1'b0;
        next_s.step = 3'h0;
        next_s.ph = 2'h0;
        next_s.qcnt = 8'h00;
        next_s.bitn = 4'h0;
      end
    end
    if (s.busy) begin
      if (!tick) begin
        next_s.qcnt = s.qcnt + 8'h01;
      end else if (s.ph == 2'h2 && !scl_s) begin
        // Target holds the clock low: wait here
        next_s.qcnt = s.qcnt;
      end else begin
        next_s.qcnt = 8'h00;
        next_s.ph = s.ph + 2'h1;
        case (s.ph)
          2'h0: begin
            case (op)
              chgi_pkg::CHGI_OP_START: next_s.sda_oe = 1'b0;
              chgi_pkg::CHGI_OP_STOP:  next_s.sda_oe = 1'b1;
              chgi_pkg::CHGI_OP_TX:
                next_s.sda_oe = (s.bitn < `CHGI_BYTE_BITS) &&
                                !s.sh[7];
              default: next_s.sda_oe = 1'b0;
            endcase
          end
          2'h1: begin
            next_s.scl_oe = 1'b0;
          end
          2'h2: begin
            if (op == chgi_pkg::CHGI_OP_START) begin
              next_s.sda_oe = 1'b1;
            end else if (op == chgi_pkg::CHGI_OP_STOP) begin
              next_s.sda_oe = 1'b0;
            end else if (s.bitn < `CHGI_BYTE_BITS) begin
              next_s.sh = {s.sh[6:0], sda_s};
            end else begin
              next_s.nack = (op == chgi_pkg::CHGI_OP_TX) && sda_s;
            end
          end
          default: begin
            if (op != chgi_pkg::CHGI_OP_STOP) begin
              next_s.scl_oe = 1'b1;
            end
            if ((op == chgi_pkg::CHGI_OP_TX || op == chgi_pkg::CHGI_OP_RX)
                && s.bitn < `CHGI_BYTE_BITS) begin
              next_s.bitn = s.bitn + 4'h1;
            end else begin
              next_s.bitn = 4'h0;
              next_s.step = s.step + 3'h1;
              if (op == chgi_pkg::CHGI_OP_TX && s.nack) begin
                next_s.step = s.rd_op ? `CHGI_H_STOP_RD
                                      : `CHGI_H_STOP_WR;
              end
              if (op == chgi_pkg::CHGI_OP_RX) begin
                next_s.rdat = s.sh;
              end
              if (op == chgi_pkg::CHGI_OP_STOP) begin
                next_s.busy = 1'b0;
              end
              next_s.sh = tx_byte(s.step + 3'h1);
            end
          end
        endcase
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign link.scl_ctl_o = 1'b0;
  assign link.scl_ctl_oe = s.scl_oe;
  assign link.sda_ctl_o = 1'b0;
  assign link.sda_ctl_oe = s.sda_oe;
  assign rdata_o = s.rdata;
  assign busy_o = s.busy;
endmodule

`default_nettype wire

/* tb/chgi_link_assertions.sv */
`timescale 1ns/1ns
`default_nettype none

module chgi_link_assertions (
  // Clock and reset
  input  wire logic core_clk_i,
  input  wire logic rst_b_i,
  // Resolved wires and pin drives of both ends
  input  wire logic scl,
  input  wire logic sda,
  input  wire logic scl_tgt_o,
  input  wire logic scl_tgt_oe,
  input  wire logic sda_tgt_o,
  input  wire logic sda_tgt_oe,
  input  wire logic scl_ctl_o,
  input  wire logic scl_ctl_oe,
  input  wire logic sda_ctl_o,
  input  wire logic sda_ctl_oe
);
  typedef struct packed {
    logic       scl_q;
    logic       sda_q;
    logic       adr;
    logic [3:0] bitc;
    logic [9:0] per;
  } chgi_mon_t;

  chgi_mon_t mon;
  chgi_mon_t next_mon;
  logic      rise;
  logic      hi2;

  assign rise = scl && !mon.scl_q;
  // Skips the first high cycle, where the bit count is still stale
  assign hi2  = scl && mon.scl_q;

  always_comb begin
    next_mon = mon;
    next_mon.scl_q = scl;
    next_mon.sda_q = sda;
    next_mon.per = (mon.per == 10'h3ff) ? mon.per : mon.per + 10'h001;
    if (rise) begin
      next_mon.per = 10'h000;
      next_mon.bitc = (mon.bitc == 4'h9) ? 4'h1 : mon.bitc + 4'h1;
      next_mon.adr = (mon.bitc == 4'h9) ? 1'b0 : mon.adr;
    end
    if (hi2 && mon.sda_q && !sda) begin
      next_mon.bitc = 4'h0;
      next_mon.adr = 1'b1;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      mon <= '{1'b1, 1'b1, 1'b0, 4'h0, 10'h3ff};
    end else begin
      mon <= next_mon;
    end
  end

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_b_i);

  property p_tgt_od; !scl_tgt_o && !sda_tgt_o; endproperty
  property p_ctl_od; !scl_ctl_o && !sda_ctl_o; endproperty
  property p_no_stretch; !scl_tgt_oe; endproperty
  property p_tgt_hold; scl && $past(scl) |-> $stable(sda_tgt_oe); endproperty
  property p_period; rise |-> mon.per >= 10'h0f9; endproperty
  property p_high_min; $rose(scl) |-> scl [*8]; endproperty
  property p_ctl_ninth; hi2 && mon.bitc == 4'h9 |-> !sda_ctl_oe; endproperty
  property p_adr_quiet;
    mon.adr && hi2 && mon.bitc != 4'h9 |-> !sda_tgt_oe;
  endproperty
  property p_adr_ack; mon.adr && hi2 && mon.bitc == 4'h9 |-> sda_tgt_oe; endproperty
  property p_stop_free; $rose(sda) && scl |=> !sda_tgt_oe [*8]; endproperty

  a_tgt_od: assert property (p_tgt_od)
    else $error("target pin drives high");
  a_ctl_od: assert property (p_ctl_od)
    else $error("controller pin drives high");
  a_no_stretch: assert property (p_no_stretch)
    else $error("target holds clock low");
  a_tgt_hold: assert property (p_tgt_hold)
    else $error("target data moved while clock high");
  a_period: assert property (p_period)
    else $error("clock period below fast rate");
  a_high_min: assert property (p_high_min)
    else $error("clock high phase too short");
  a_ctl_ninth: assert property (p_ctl_ninth)
    else $error("controller drives data on ninth clock");
  a_adr_quiet: assert property (p_adr_quiet)
    else $error("target drives during address byte");
  a_adr_ack: assert property (p_adr_ack)
    else $error("target missed address acknowledge");
  a_stop_free: assert property (p_stop_free)
    else $error("target drives data after stop");

  c_adr_ack: cover property (mon.adr && hi2 && mon.bitc == 4'h9 && sda_tgt_oe);
  c_rd_bit: cover property (!mon.adr && hi2 && mon.bitc != 4'h9 && sda_tgt_oe);
  c_nack: cover property (!mon.adr && hi2 && mon.bitc == 4'h9 && sda);
endmodule

`default_nettype wire

/* tb/test_charger_i2c_host_port.sv */
`timescale 1ns/1ns
`default_nettype none

module test_charger_i2c_host_port;
  logic       core_clk_i;
  logic       rst_b_i;
  logic [3:0] addr;
  logic [7:0] wdata, rdata, stat0, fault, stat2;
  logic       wr, rd, busy, oc, sexit, fet, ship, hmode, chg, int_b;
  int         failures;
  int         compares;

  chgi_link_if lnk ();

  chgi_target #(.INT_CYCLES(16), .SAFETY_CYCLES(200), .WDT_STEP_CYCLES(8000))
    chgi_target_inst (.core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .link(lnk),
    .stat0_i(stat0), .fault_i(fault), .stat2_i(stat2),
    .discharge_current_limit_hit_i(oc), .ship_exit_i(sexit),
    .battery_fet_on_o(fet), .ship_mode_o(ship), .host_mode_o(hmode),
    .charge_en_o(chg), .int_b_o(int_b));

  chgi_host chgi_host_inst (.core_clk_i(core_clk_i), .rst_b_i(rst_b_i),
    .link(lnk), .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd),
    .rdata_o(rdata), .busy_o(busy));

  chgi_link_assertions chgi_link_assertions_inst (.core_clk_i(core_clk_i),
    .rst_b_i(rst_b_i), .scl(lnk.scl), .sda(lnk.sda),
    .scl_tgt_o(lnk.scl_tgt_o), .scl_tgt_oe(lnk.scl_tgt_oe),
    .sda_tgt_o(lnk.sda_tgt_o), .sda_tgt_oe(lnk.sda_tgt_oe),
    .scl_ctl_o(lnk.scl_ctl_o), .scl_ctl_oe(lnk.scl_ctl_oe),
    .sda_ctl_o(lnk.sda_ctl_o), .sda_ctl_oe(lnk.sda_ctl_oe));

  initial begin
    core_clk_i = 1'b0;
    forever #5 core_clk_i = ~core_clk_i;
  end

  task automatic end_sim();
    $display("compares=%0d failures=%0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] e, input logic [7:0] g);
    compares++;
    if (g !== e) begin
      failures++;
      $display("BAD t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask

  task automatic sw_wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge core_clk_i);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge core_clk_i);
    wr <= 1'b0;
  endtask

  task automatic sw_rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge core_clk_i);
    addr <= a;
    rd <= 1'b1;
    @(posedge core_clk_i);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask

  // Busy is watched for its rise, so a refused go cannot pass as done
  task automatic xfer(input logic [7:0] p, input logic [7:0] d,
                      input logic [7:0] go);
    int   n;
    logic seen;
    seen = 1'b0;
    sw_wr(4'h1, p);
    sw_wr(4'h2, d);
    sw_wr(4'h0, go);
    for (n = 0; n < 12000; n++) begin
      @(posedge core_clk_i);
      #1;
      if (busy === 1'b1) begin
        seen = 1'b1;
      end else if (seen) begin
        break;
      end
    end
    if (n == 12000) begin
      failures++;
      end_sim();
    end
  endtask

  task automatic rd_reg(input logic [7:0] p, output logic [7:0] d);
    xfer(p, 8'h00, 8'h02);
    sw_rd(4'h4, d);
  endtask

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge core_clk_i);
    #1;
  endtask

  task automatic t_reset();
    logic [7:0] d;
    chk(8'h01, 8'(chg));
    chk(8'h00, 8'(hmode));
    chk(8'h01, 8'(int_b));
    rd_reg(8'h00, d);
    chk(8'h17, d);
    rd_reg(8'h01, d);
    chk(8'h1a, d);
    rd_reg(8'h09, d);
    chk(8'h80, d);
    chk(8'h00, 8'(chg));
    $display("test reset done");
  endtask

  task automatic t_regs();
    logic [7:0] d;
    stat0 <= 8'h3c;
    xfer(8'h0c, 8'ha5, 8'h01);
    chk(8'h01, 8'(hmode));
    chk(8'h01, 8'(chg));
    rd_reg(8'h0c, d);
    chk(8'ha5, d);
    xfer(8'h08, 8'h55, 8'h01);
    rd_reg(8'h08, d);
    chk(8'h3c, d);
    rd_reg(8'h0d, d);
    sw_rd(4'h3, d);
    chk(8'h02, d);
    sw_rd(4'h5, d);
    chk(8'h00, d);
    $display("test regs done");
  endtask

  task automatic t_fault();
    logic [7:0] d;
    int         n;
    fault <= 8'h04;
    wait_cyc(3);
    fault <= 8'h00;
    for (n = 0; n < 20 && int_b !== 1'b0; n++) begin
      wait_cyc(1);
    end
    chk(8'h00, 8'(int_b));
    wait_cyc(24);
    stat2 <= 8'h10;
    fault <= 8'h02;
    wait_cyc(1);
    stat2 <= 8'h00;
    fault <= 8'h00;
    repeat (40) begin
      wait_cyc(1);
      chk(8'h01, 8'(int_b));
    end
    rd_reg(8'h09, d);
    chk(8'h06, d);
    rd_reg(8'h0a, d);
    chk(8'h10, d);
    rd_reg(8'h09, d);
    chk(8'h00, d);
    rd_reg(8'h0a, d);
    chk(8'h00, d);
    fault <= 8'h01;
    wait_cyc(2);
    fault <= 8'h00;
    chk(8'h00, 8'(int_b));
    $display("test fault done");
  endtask

  task automatic t_ship();
    oc <= 1'b1;
    sexit <= 1'b1;
    wait_cyc(1);
    oc <= 1'b0;
    sexit <= 1'b0;
    wait_cyc(3);
    chk(8'h01, 8'(ship));
    chk(8'h00, 8'(fet));
    sexit <= 1'b1;
    wait_cyc(1);
    sexit <= 1'b0;
    wait_cyc(3);
    chk(8'h00, 8'(ship));
    chk(8'h01, 8'(fet));
    $display("test ship done");
  endtask

  task automatic t_wdog();
    int n;
    xfer(8'h05, 8'h10, 8'h01);
    chk(8'h01, 8'(hmode));
    xfer(8'h01, 8'h40, 8'h01);
    // Past the unkicked expiry point, well before the kicked one
    wait_cyc(600);
    chk(8'h01, 8'(hmode));
    for (n = 0; n < 9000 && hmode !== 1'b0; n++) begin
      wait_cyc(1);
    end
    chk(8'h00, 8'(hmode));
    $display("test watchdog done");
  endtask

  initial begin
    rst_b_i = 1'b0;
    {addr, wdata, wr, rd, stat0, fault, stat2, oc, sexit} = '0;
    failures = 0;
    compares = 0;
    repeat (8) @(posedge core_clk_i);
    rst_b_i <= 1'b1;
    wait_cyc(4);
    t_reset();
    t_regs();
    t_fault();
    t_ship();
    t_wdog();
    end_sim();
  end
endmodule

`default_nettype wire
